/* File: sppd_top.sv */
// Notes on behaviour
// - Mode not all ones: divide by 24-bit field
// - Regular divide gives nominal half duty cycle
// - Odd small divides may skew duty, worst 33% at ratio 3
// - Even or odd >= 41 stays within 45-55%
// - Bits 17:16 select source only in special mode
// - Source 00/01/10 siblings A/B/C, 11 low-frequency
// - Frame pulse width is one sibling period
// - Low-frequency clock: double base over low field
// - Bit 18 sets frame pulse polarity
// - Bit 19 sets mid-pulse or first-edge boundary
// - Low field counts source periods between pulses
`timescale 1ns/1ps
module sppd_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sibling post-divider clocks A, B, C (sampled on clk_i)
  input wire logic [2:0] sib_clk_i,
  // Tick at twice the synthesizer base frequency
  input wire logic base2x_tick_i,
  // Divided clock or frame pulse output
  output logic out_o,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [11:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic do_write;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;
  logic rvalid_d;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit_cfg;
  logic wr_hit_stat;
  logic [23:0] staged_q;
  logic [23:0] staged_d;
  logic [2:0] lanes_q;
  logic [2:0] lanes_d;
  logic commit;
  logic [23:0] divider_d_value_q;
  sppd_pkg::sppd_cfg_s cfg;
  sppd_pkg::sppd_mode_e mode_q;
  sppd_pkg::sppd_mode_e mode_d;
  logic restart_q;
  logic reg_level;
  logic lf_level;
  logic sib_level;
  logic sib_rise;
  logic sib_fall;
  logic [15:0] fr_cnt_q;
  logic [15:0] fr_last;
  logic fr_boundary;
  logic fr_event;
  logic pulse_q;
  logic out_d;
  logic [31:0] rd_data;
  logic rd_hit;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------------

  // Address and data are taken independently and held until both arrive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_addr_q <= 12'h000;
      aw_held_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_q <= s_axi_awaddr;
      aw_held_q <= 1'b1;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data holding register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      w_held_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      w_held_q <= 1'b1;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Next held and response state, as the flops will take it at the edge
  assign aw_held_d = (s_axi_awvalid & s_axi_awready) | (aw_held_q & ~do_write);
  assign w_held_d = (s_axi_wvalid & s_axi_wready) | (w_held_q & ~do_write);
  assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_d = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

  // Ready only while the slot is empty and no response is pending; the
  // ready flops look one state ahead so the bus outputs stay registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready <= ~w_held_d & ~bvalid_d;
      s_axi_arready <= ~rvalid_d; // One read at a time
    end
  end

  // Write happens in the first cycle that both halves are held and no response is pending
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign wr_hit_cfg = (wr_addr == sppd_pkg::CFG_ADDR);
  assign wr_hit_stat = (wr_addr == sppd_pkg::STAT_ADDR);

  // Write response; status is read-only so a write there is still OKAY
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sppd_pkg::AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_hit_cfg || wr_hit_stat) ? sppd_pkg::AXI_OKAY :
                     sppd_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration register with byte staging
  // ----------------------------------------------------------------------

  // Merge written byte lanes into the staging copy and track which landed
  always_comb begin
    staged_d = staged_q;
    lanes_d = lanes_q;
    if (do_write && wr_hit_cfg) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_strb[i]) begin
          staged_d[i*8 +: 8] = wr_data[i*8 +: 8];
          lanes_d[i] = 1'b1;
        end
      end
    end
    commit = (lanes_d == sppd_pkg::CFG_LANES_ALL);
  end

  // Staging copy is what software reads back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      staged_q <= sppd_pkg::CFG_RESET;
      lanes_q <= 3'h0;
    end else begin
      staged_q <= staged_d;
      lanes_q <= commit ? 3'h0 : lanes_d;
    end
  end

  // Active setting changes only as a whole word, never a byte mix
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divider_d_value_q <= sppd_pkg::CFG_RESET;
      restart_q <= 1'b0;
    end else begin
      restart_q <= commit;
      if (commit) begin
        divider_d_value_q <= staged_d;
      end
    end
  end

  assign cfg = divider_d_value_q;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------

  // Source bits only mean a source when the mode nibble is all ones
  always_comb begin
    if (cfg.mode != sppd_pkg::MODE_SPECIAL) begin
      mode_d = sppd_pkg::SPPD_REGULAR;
    end else if (cfg.src == sppd_pkg::SRC_LOW_FREQ) begin
      mode_d = sppd_pkg::SPPD_LOW_FREQ;
    end else begin
      mode_d = sppd_pkg::SPPD_FRAME;
    end
  end

  // Registered mode keeps the output mux off the decode path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= sppd_pkg::SPPD_REGULAR;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------------
  // Regular and low-frequency dividers
  // ----------------------------------------------------------------------

  // Whole 24 bits as ratio; high for floor half, so odd ratios skew
  // slightly, worst at small ratios, and even ratios are exact
  sppd_divider u_reg_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(1'b1),
    .restart_i(restart_q),
    .ratio_i(divider_d_value_q),
    .level_o(reg_level)
  );

  // Counts ticks at twice the base rate, ratio from the low field
  sppd_divider u_lf_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(base2x_tick_i),
    .restart_i(restart_q),
    .ratio_i({8'h00, cfg.rate}),
    .level_o(lf_level)
  );

  // ----------------------------------------------------------------------
  // Frame pulse generator
  // ----------------------------------------------------------------------

  // Sibling A, B or C chosen by the source bits
  always_comb begin
    unique case (cfg.src)
      2'h0: sib_level = sib_clk_i[0];
      2'h1: sib_level = sib_clk_i[1];
      2'h2: sib_level = sib_clk_i[2];
      2'h3: sib_level = 1'b0;
    endcase
  end

  sppd_edge u_sib_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(sib_level),
    .rise_o(sib_rise),
    .fall_o(sib_fall)
  );

  // Rate of zero would never wrap, so it acts as one
  assign fr_last = (cfg.rate == 16'h0000) ? 16'h0000 : cfg.rate - 16'h0001;
  assign fr_boundary = (fr_cnt_q == fr_last);

  // Counts sibling periods; the wrap rising edge is the frame boundary
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_cnt_q <= 16'h0000;
    end else if (restart_q) begin
      fr_cnt_q <= 16'h0000;
    end else if (sib_rise) begin
      fr_cnt_q <= fr_boundary ? 16'h0000 : fr_cnt_q + 16'h0001;
    end
  end

  // First-edge format steps on rising edges; mid-pulse format steps on
  // falling edges, so the boundary falls half way through the pulse
  assign fr_event = cfg.fmt ? sib_rise : sib_fall;

  // Pulse lasts exactly one sibling period between two like edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_q <= 1'b0;
    end else if (restart_q) begin
      pulse_q <= 1'b0;
    end else if (fr_event) begin
      pulse_q <= fr_boundary;
    end
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------

  // Select per mode; polarity bit inverts the frame pulse only
  always_comb begin
    unique case (mode_q)
      sppd_pkg::SPPD_REGULAR: out_d = reg_level;
      sppd_pkg::SPPD_LOW_FREQ: out_d = lf_level;
      sppd_pkg::SPPD_FRAME: out_d = pulse_q ^ cfg.pol;
      default: out_d = 1'b0;
    endcase
  end

  // Output straight from a flop to keep it glitch free
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_o <= 1'b0;
    end else begin
      out_o <= out_d;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------------

  // Read mux: staged config, or live status of the block
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == sppd_pkg::CFG_ADDR) begin
      rd_data = {8'h00, staged_q};
    end else if (s_axi_araddr == sppd_pkg::STAT_ADDR) begin
      rd_data = {26'h0000000, out_o, lanes_q, mode_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read at a time; answered one cycle after the address is taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sppd_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? sppd_pkg::AXI_OKAY : sppd_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sppd_top

/* File: sppd_pkg.sv */
package sppd_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CFG_REG_INDEX = 12'h089;
  localparam logic [11:0] CFG_ADDR = 12'h224;
  localparam logic [11:0] STAT_ADDR = 12'h230;
  localparam logic [23:0] CFG_RESET = 24'h000040;
  localparam logic [2:0] CFG_LANES_ALL = 3'h7;

  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int MODE_LSB = 20;
  localparam int FMT_BIT = 19;
  localparam int POL_BIT = 18;
  localparam int SRC_LSB = 16;
  localparam logic [3:0] MODE_SPECIAL = 4'hf;
  localparam logic [1:0] SRC_LOW_FREQ = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Configuration word, same bit order as the register
  typedef struct packed {
    logic [3:0] mode;
    logic fmt;
    logic pol;
    logic [1:0] src;
    logic [15:0] rate;
  } sppd_cfg_s;

  // Output modes decoded from the active configuration
  typedef enum logic [1:0] {
    SPPD_REGULAR = 2'b00,
    SPPD_LOW_FREQ = 2'b01,
    SPPD_FRAME = 2'b10
  } sppd_mode_e;

endpackage : sppd_pkg

/* File: sppd_edge.sv */
`timescale 1ns/1ps
module sppd_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sampled level and its edges
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_q;

  // Previous level for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  // One-cycle edge pulses
  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : sppd_edge

/* File: sppd_divider.sv */
`timescale 1ns/1ps
module sppd_divider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic en_i,
  input wire logic restart_i,
  input wire logic [23:0] ratio_i,
  // Divided level
  output logic level_o
);

  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic [23:0] last;
  logic [23:0] half;

  // Ratios below two cannot be made from this clock, so they act as two
  always_comb begin
    last = (ratio_i < 24'h000002) ? 24'h000001 : ratio_i - 24'h000001;
    half = (last + 24'h000001) >> 1;
    cnt_d = (cnt_q >= last) ? 24'h000000 : cnt_q + 24'h000001;
  end

  // Counter wraps at ratio; high for the first half of each period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 24'h000000;
      level_o <= 1'b0;
    end else if (restart_i) begin
      cnt_q <= 24'h000000;
      level_o <= 1'b0;
    end else if (en_i) begin
      cnt_q <= cnt_d;
      level_o <= (cnt_d < half);
    end
  end

endmodule : sppd_divider

/* File: sppd_top_monitor.sv */
`timescale 1ns/1ps
module sppd_top_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Output and bus handshakes
  input wire logic out_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ------
  // Run length of out_o
  // ------
  logic [15:0] run_q;
  logic last_q;
  logic seen_q;
  logic touched_q;

  // Judged only while the reset setting is untouched; the first high run is one short
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 16'h0000;
      last_q <= 1'b0;
      seen_q <= 1'b0;
      touched_q <= 1'b0;
    end else begin
      run_q <= (out_o != last_q) ? 16'h0001 : run_q + 16'h0001;
      last_q <= out_o;
      seen_q <= seen_q | (last_q & ~out_o);
      touched_q <= touched_q | s_axi_awvalid;
    end
  end

  // Address and data halves taken
  sequence s_aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence

  chk_write_answer: assert property ((s_aw_take and s_w_take) |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_high_half: assert property (
    $fell(out_o) && seen_q && !touched_q |-> run_q == 16'h0020)
    else $error("default high phase not 32 cycles");
  chk_low_half: assert property (
    $rose(out_o) && seen_q && !touched_q |-> run_q == 16'h0020)
    else $error("default low phase not 32 cycles");
endmodule : sppd_top_monitor

bind sppd_top sppd_top_monitor sppd_top_monitor_inst (
  .clk_i, .rst_n_i, .out_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

/* File: sppd_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module sppd_top_tb;
  // ------
  // Stimulus
  // ------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] sib_clk_i = 3'h0;
  logic base2x_tick_i = 1'b0;
  logic out_o;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  // Siblings A/B/C of 16/6/10 cycles; A is slow so pulse phase survives the output latency
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    base2x_tick_i <= (cyc % 4 == 3);
    sib_clk_i <= {(cyc % 10) < 5, (cyc % 6) < 3, (cyc % 16) < 8};
  end

  sppd_top sppd_top_inst (
    .clk_i, .rst_n_i, .sib_clk_i, .base2x_tick_i, .out_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // One write or read; resp 2'h1 never comes back, so it marks a missing answer
  task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h1;
    q = 32'h0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (r === 2'h1 && n < 200) begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : axi

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'b1, a, d, s, q, r);
    `CHK(r, er)
  endtask : wr_chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'b0, a, 32'h0, 4'h0, q, r);
    `CHK(r, er)
    `CHK(q & m, e)
  endtask : rd_chk

  // Counts cycles while out_o holds level b, sampled on the falling edge
  task automatic hold(input logic b, output int n);
    n = 0;
    while (out_o === b && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : hold

  // Skips level runs up to the second rise of out_o so a restart never leaves a partial phase in the count
  task automatic measure(input int hi, input int lo, output logic ph);
    int h;
    int l;
    for (int k = 0; k < 4; k++) hold(~k[0], h);
    ph = sib_clk_i[0];
    hold(1'b1, h);
    hold(1'b0, l);
    `CHK(h, hi)
    `CHK(l, lo)
  endtask : measure

  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    logic ph;
    rd_chk(sppd_pkg::CFG_ADDR, 32'hffffffff, {8'h00, sppd_pkg::CFG_RESET}, sppd_pkg::AXI_OKAY);
    measure(32, 32, ph);
    wr_chk(12'h300, 32'h00000003, 4'hf, sppd_pkg::AXI_SLVERR);
    rd_chk(12'h300, 32'hffffffff, 32'h0, sppd_pkg::AXI_SLVERR);
    wr_chk(sppd_pkg::STAT_ADDR, 32'h0, 4'hf, sppd_pkg::AXI_OKAY);
    rd_chk(sppd_pkg::CFG_ADDR, 32'hffffffff, {8'h00, sppd_pkg::CFG_RESET}, sppd_pkg::AXI_OKAY);
  endtask : t_regs

  // A lone low byte is staged only; the output keeps the old divide until all lanes land
  task automatic t_lanes();
    logic ph;
    wr_chk(sppd_pkg::CFG_ADDR, 32'h00000005, 4'h1, sppd_pkg::AXI_OKAY);
    rd_chk(sppd_pkg::STAT_ADDR, 32'h1c, 32'h04, sppd_pkg::AXI_OKAY);
    measure(32, 32, ph);
    wr_chk(sppd_pkg::CFG_ADDR, 32'h0, 4'h6, sppd_pkg::AXI_OKAY);
    rd_chk(sppd_pkg::STAT_ADDR, 32'h1c, 32'h0, sppd_pkg::AXI_OKAY);
    measure(2, 3, ph);
  endtask : t_lanes

  // Odd, even, odd at the 41 boundary, smallest divide, the even 8 that
  // software may use in place of 7, then the low-frequency clock
  task automatic t_divide();
    logic [23:0] c[6] = '{24'h000007, 24'h00000a, 24'h000029, 24'h000002, 24'h000008,
                          24'hf30006};
    int hi[6] = '{3, 5, 20, 1, 4, 12};
    int lo[6] = '{4, 5, 21, 1, 4, 12};
    logic ph;
    for (int i = 0; i < 6; i++) begin
      wr_chk(sppd_pkg::CFG_ADDR, {8'ha5, c[i]}, 4'hf, sppd_pkg::AXI_OKAY);
      rd_chk(sppd_pkg::CFG_ADDR, 32'hffffffff, {8'h00, c[i]}, sppd_pkg::AXI_OKAY);
      rd_chk(sppd_pkg::STAT_ADDR, 32'h3, (i == 5) ? 32'h1 : 32'h0, sppd_pkg::AXI_OKAY);
      measure(hi[i], lo[i], ph);
    end
  endtask : t_divide

  // Pulse width, spacing, polarity, format and each sibling
  task automatic t_frame();
    logic [23:0] c[5] = '{24'hf80003, 24'hf00003, 24'hfc0003, 24'hf90004, 24'hfa0002};
    int hi[5] = '{16, 16, 32, 6, 10};
    int lo[5] = '{32, 32, 16, 18, 10};
    logic ph;
    for (int i = 0; i < 5; i++) begin
      wr_chk(sppd_pkg::CFG_ADDR, {8'h00, c[i]}, 4'hf, sppd_pkg::AXI_OKAY);
      rd_chk(sppd_pkg::STAT_ADDR, 32'h3, 32'h2, sppd_pkg::AXI_OKAY);
      measure(hi[i], lo[i], ph);
      if (i < 3) `CHK(ph, c[i][19])
    end
  endtask : t_frame

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_lanes();
    t_divide();
    t_frame();
    end_of_test();
  end

  // The whole run needs a few thousand cycles; 50000 leaves a wide margin
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule : sppd_top_tb
